// ---- include/capture_consts.svh ----
// capture_consts.svh: register offsets, fields, reset values and timing counts of the
// triggered sample capture unit. Included by the design modules and the testbench.
`ifndef CAPTURE_CONSTS_SVH
`define CAPTURE_CONSTS_SVH

`define CAP_ADDR_CTRL        8'h00
`define CAP_ADDR_RATE        8'h04
`define CAP_ADDR_PERIOD      8'h08
`define CAP_ADDR_DURATION    8'h0C
`define CAP_ADDR_PRE_OFFSET  8'h10
`define CAP_ADDR_BLOCK_SIZE  8'h14
`define CAP_ADDR_SUBBLOCKS   8'h18
`define CAP_ADDR_STATUS      8'h1C
`define CAP_ADDR_TIMESTAMP   8'h20

`define CAP_CTRL_EN_BIT      0
`define CAP_CTRL_MODE_LSB    1
`define CAP_STAT_RUN_BIT     0
`define CAP_STAT_BLK_LSB     8

`define CAP_RESP_OKAY        2'h0
`define CAP_RESP_SLVERR      2'h2

`define CAP_BLOCK_RATE_HZ    32'h0000000A
`define CAP_DURATION_MS      1000
`define CAP_RST_RATE_HZ      32'h0000000A
`define CAP_RST_DURATION     32'(`CAP_DURATION_MS * 10 / 1000)
`define CAP_RST_PERIOD       32'h00000001
`define CAP_RST_PRE_OFFSET   32'h00000000
`define CAP_RST_BLOCK_SIZE   32'h00000100
`define CAP_RST_SUBBLOCKS    32'h00000001
`define CAP_RST_CTRL         32'h00000000

`define CAP_MEM_AW           8
`define CAP_DW               32

`endif

// ---- include/capture_pkg.sv ----
// capture_pkg: types shared by the capture unit's modules.
// assumes capture_consts.svh on the include path.
`default_nettype none
package capture_pkg;
  typedef enum logic [1:0] {mode_single, mode_fixed, mode_gated, mode_cont} mode_type;
  typedef enum logic {cap_idle, cap_run} cap_state_type;
endpackage
`default_nettype wire

// ---- core/pretrig_mem.sv ----
// pretrig_mem: history of recent samples, one write port and one registered read port.
// assumes clk_sys domain; read and write addresses may be equal only with old data read.
`include "capture_consts.svh"
`default_nettype none
module pretrig_mem (
  input  wire logic                     clk_sys,  // system clock
  input  wire logic                     wr_en,    // write strobe
  input  wire logic [`CAP_MEM_AW-1:0]   wr_addr,  // write slot
  input  wire logic [`CAP_DW-1:0]       wr_data,  // sample to keep
  input  wire logic [`CAP_MEM_AW-1:0]   rd_addr,  // read slot
  output logic      [`CAP_DW-1:0]       rd_data   // registered read data
);
  logic [`CAP_DW-1:0] mem [0:(1<<`CAP_MEM_AW)-1];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // pretrig_mem
`default_nettype wire

// ---- core/strobed_sample_capture.sv ----
// strobed_sample_capture: triggered capture of an upstream sample stream into timestamped
// records, configured over AXI4-Lite. assumes trigger and samples come from clk_sys logic.
// Contract
// RULE1: in one-point mode one sample is stored per rising trigger edge.
// RULE2: a nonzero pre-trigger offset picks the sample that far back and moves the stamp too; here only one-point mode applies the offset.
// RULE3: in fixed-length mode a rising edge starts a capture of a set number of points.
// RULE4: below ten hertz every captured point is a record of its own with a timestamp.
// RULE5: at ten hertz or more points are packed in blocks with one leading timestamp.
// RULE6: a fixed capture longer than a block is split into consecutive sub-blocks.
// RULE7: in gated mode samples are taken only while the trigger is high.
// RULE8: in gated block mode a started block is always completed.
// RULE9: in continuous mode the trigger is ignored and capture never pauses.
// RULE10: the configuring party should keep the automatic block settings.
// RULE11: for fast continuous recording a stream store should be used instead.
// RULE12: the configuring party names the record store with four characters.
// RULE13: all timestamps come from a free-running sample counter.
`include "capture_consts.svh"
`default_nettype none
module strobed_sample_capture
  import capture_pkg::*;
(
  input  wire logic        clk_sys,        // system clock, 100 MHz
  input  wire logic        rst_b,          // async reset, active low
  input  wire logic        sample_tick,    // one pulse per upstream sample
  input  wire logic [31:0] sample_data,    // upstream sample value
  input  wire logic        trig,           // logical trigger input
  input  wire logic [7:0]  s_axi_awaddr,   // write address
  input  wire logic        s_axi_awvalid,  // write address valid
  output logic             s_axi_awready,  // write address ready
  input  wire logic [31:0] s_axi_wdata,    // write data
  input  wire logic [3:0]  s_axi_wstrb,    // byte enables
  input  wire logic        s_axi_wvalid,   // write data valid
  output logic             s_axi_wready,   // write data ready
  output logic [1:0]       s_axi_bresp,    // write response
  output logic             s_axi_bvalid,   // write response valid
  input  wire logic        s_axi_bready,   // write response ready
  input  wire logic [7:0]  s_axi_araddr,   // read address
  input  wire logic        s_axi_arvalid,  // read address valid
  output logic             s_axi_arready,  // read address ready
  output logic [31:0]      s_axi_rdata,    // read data
  output logic [1:0]       s_axi_rresp,    // read response
  output logic             s_axi_rvalid,   // read data valid
  input  wire logic        s_axi_rready,   // read data ready
  output logic             rec_valid,      // one record beat
  output logic             rec_has_time,   // beat opens a record with a timestamp
  output logic [31:0]      rec_time,       // timestamp of the record
  output logic [31:0]      rec_value,      // captured sample
  output logic             rec_block_end   // last beat of a record
);
  logic [31:0] ctrl_reg, rate_reg, period_reg, dur_reg, pre_reg, bsize_reg, nsub_reg;
  logic [31:0] ts_reg, div_reg, pts_left_reg, blk_pos_reg, blk_cnt_reg;
  logic [`CAP_MEM_AW-1:0] wptr_reg;
  logic [31:0] mem_rdata, held_value_reg, held_time_reg;
  logic        trig_d_reg, single_pend_reg, held_zero_reg;
  cap_state_type state_reg;

  logic        aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg;
  logic [3:0]  w_strb_reg;
  logic [1:0]  bresp_reg, rresp_reg;

  mode_type    mode;
  logic        enable, block_mode, trig_rise, start_cond, cap_ok, cap_tick;
  logic        blk_wrap, last_point, wr_fire, rd_fire, addr_ok;
  logic [31:0] period_m1, bsize_m1;

  assign mode       = mode_type'(ctrl_reg[`CAP_CTRL_MODE_LSB +: 2]);
  assign enable     = ctrl_reg[`CAP_CTRL_EN_BIT];
  assign block_mode = rate_reg >= `CAP_BLOCK_RATE_HZ;
  assign trig_rise  = trig & ~trig_d_reg;
  assign period_m1  = (period_reg == 32'h00000000) ? 32'h00000000 : period_reg - 32'h00000001;
  assign bsize_m1   = (bsize_reg == 32'h00000000) ? 32'h00000000 : bsize_reg - 32'h00000001;
  assign blk_wrap   = blk_pos_reg == bsize_m1;

  // ---------------- AXI4-Lite slave ----------------
  assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign wr_fire       = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign rd_fire       = s_axi_arvalid & ~rvalid_reg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  // writable word addresses; status and timestamp are read-only
  always_comb begin
    case (aw_addr_reg)
      `CAP_ADDR_CTRL, `CAP_ADDR_RATE, `CAP_ADDR_PERIOD, `CAP_ADDR_DURATION,
      `CAP_ADDR_PRE_OFFSET, `CAP_ADDR_BLOCK_SIZE, `CAP_ADDR_SUBBLOCKS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `CAP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= addr_ok ? `CAP_RESP_OKAY : `CAP_RESP_SLVERR;
      end else if (bvalid_reg & s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg   <= `CAP_RST_CTRL;
      rate_reg   <= `CAP_RST_RATE_HZ;
      period_reg <= `CAP_RST_PERIOD;
      dur_reg    <= `CAP_RST_DURATION;
      pre_reg    <= `CAP_RST_PRE_OFFSET;
      bsize_reg  <= `CAP_RST_BLOCK_SIZE;
      nsub_reg   <= `CAP_RST_SUBBLOCKS;
    end else if (wr_fire) begin
      case (aw_addr_reg)
        `CAP_ADDR_CTRL:       ctrl_reg   <= merge(ctrl_reg, w_data_reg, w_strb_reg) & 32'h7;
        `CAP_ADDR_RATE:       rate_reg   <= merge(rate_reg, w_data_reg, w_strb_reg);
        `CAP_ADDR_PERIOD:     period_reg <= merge(period_reg, w_data_reg, w_strb_reg);
        `CAP_ADDR_DURATION:   dur_reg    <= merge(dur_reg, w_data_reg, w_strb_reg);
        `CAP_ADDR_PRE_OFFSET: pre_reg    <= merge(pre_reg, w_data_reg, w_strb_reg) & 32'hFF;
        `CAP_ADDR_BLOCK_SIZE: bsize_reg  <= merge(bsize_reg, w_data_reg, w_strb_reg);
        `CAP_ADDR_SUBBLOCKS:  nsub_reg   <= merge(nsub_reg, w_data_reg, w_strb_reg);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `CAP_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= `CAP_RESP_OKAY;
      case (s_axi_araddr)
        `CAP_ADDR_CTRL:       rdata_reg <= ctrl_reg;
        `CAP_ADDR_RATE:       rdata_reg <= rate_reg;
        `CAP_ADDR_PERIOD:     rdata_reg <= period_reg;
        `CAP_ADDR_DURATION:   rdata_reg <= dur_reg;
        `CAP_ADDR_PRE_OFFSET: rdata_reg <= pre_reg;
        `CAP_ADDR_BLOCK_SIZE: rdata_reg <= bsize_reg;
        `CAP_ADDR_SUBBLOCKS:  rdata_reg <= nsub_reg;
        `CAP_ADDR_STATUS: begin
          rdata_reg <= {16'h0000, blk_cnt_reg[7:0], 7'h00, state_reg == cap_run};
        end
        `CAP_ADDR_TIMESTAMP:  rdata_reg <= ts_reg;
        default: begin
          rdata_reg <= 32'h00000000;
          rresp_reg <= `CAP_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg & s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ---------------- sample history and timestamp ----------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ts_reg     <= 32'h00000000;
      wptr_reg   <= '0;
      trig_d_reg <= 1'b0;
    end else begin
      trig_d_reg <= trig;
      if (sample_tick) begin
        ts_reg   <= ts_reg + 32'h00000001; // RULE13
        wptr_reg <= wptr_reg + 1'b1;
      end
    end
  end

  // the newest sample sits one slot behind the write pointer
  pretrig_mem u_hist (
    .clk_sys (clk_sys),
    .wr_en   (sample_tick),
    .wr_addr (wptr_reg),
    .wr_data (sample_data),
    .rd_addr (wptr_reg - pre_reg[`CAP_MEM_AW-1:0] - 8'h01), // RULE2
    .rd_data (mem_rdata)
  );

  // one-point capture: value looked up one cycle after the edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      single_pend_reg <= 1'b0;
      held_zero_reg   <= 1'b1;
      held_value_reg  <= 32'h00000000;
      held_time_reg   <= 32'h00000000;
    end else begin
      single_pend_reg <= enable & (mode == mode_single) & trig_rise; // RULE1
      if (trig_rise) begin
        held_zero_reg  <= pre_reg == 32'h00000000;
        held_value_reg <= sample_data;
        held_time_reg  <= ts_reg - pre_reg; // RULE2
      end
    end
  end

  // ---------------- multi-point capture ----------------
  assign start_cond = enable & (((mode == mode_fixed) & trig_rise) // RULE3
                    | ((mode == mode_gated) & trig) | (mode == mode_cont)); // RULE9
  assign cap_ok     = (mode != mode_gated) | trig
                    | (block_mode & (blk_pos_reg != 32'h00000000)); // RULE7 RULE8
  assign cap_tick   = (state_reg == cap_run) & sample_tick & (div_reg == 32'h00000000) & cap_ok;
  assign last_point = (mode == mode_fixed) & ((pts_left_reg == 32'h00000001)
                    | (block_mode & blk_wrap & (blk_cnt_reg + 32'h00000001 >= nsub_reg)));

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= cap_idle;
    end else begin
      case (state_reg)
        cap_idle: if (start_cond && mode != mode_single) state_reg <= cap_run;
        cap_run: begin
          if (!enable || !cap_ok || (cap_tick && last_point)) begin
            state_reg <= cap_idle;
          end
        end
        default: state_reg <= cap_idle;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_reg      <= 32'h00000000;
      pts_left_reg <= 32'h00000000;
      blk_pos_reg  <= 32'h00000000;
      blk_cnt_reg  <= 32'h00000000;
    end else if (state_reg == cap_idle) begin
      div_reg      <= 32'h00000000;
      pts_left_reg <= dur_reg;
      blk_pos_reg  <= 32'h00000000;
      blk_cnt_reg  <= 32'h00000000;
    end else begin
      if (sample_tick) begin
        div_reg <= (div_reg >= period_m1) ? 32'h00000000 : div_reg + 32'h00000001;
      end
      if (cap_tick) begin
        pts_left_reg <= pts_left_reg - 32'h00000001; // RULE3
        blk_pos_reg  <= blk_wrap ? 32'h00000000 : blk_pos_reg + 32'h00000001; // RULE5
        if (blk_wrap) begin
          blk_cnt_reg <= blk_cnt_reg + 32'h00000001; // RULE6
        end
      end
    end
  end

  // ---------------- record output ----------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rec_valid     <= 1'b0;
      rec_has_time  <= 1'b0;
      rec_time      <= 32'h00000000;
      rec_value     <= 32'h00000000;
      rec_block_end <= 1'b0;
    end else begin
      rec_valid <= single_pend_reg | cap_tick;
      if (single_pend_reg) begin
        rec_has_time  <= 1'b1; // RULE1
        rec_time      <= held_time_reg;
        rec_value     <= held_zero_reg ? held_value_reg : mem_rdata; // RULE2
        rec_block_end <= 1'b1;
      end else if (cap_tick) begin
        rec_has_time  <= ~block_mode | (blk_pos_reg == 32'h00000000); // RULE4 RULE5
        rec_time      <= ts_reg;
        rec_value     <= sample_data;
        rec_block_end <= ~block_mode | blk_wrap | last_point; // RULE6
      end
    end
  end

  // ---------------- assertions ----------------
  property p_single_one;
    @(posedge clk_sys) disable iff (!rst_b)
    enable & (mode == mode_single) & trig_rise |-> ##2 rec_valid & rec_has_time & rec_block_end;
  endproperty
  a_single_one: assert property (p_single_one) else $error("one-point capture missing"); // RULE1

  property p_single_time;
    @(posedge clk_sys) disable iff (!rst_b)
    enable & (mode == mode_single) & trig_rise |->
      ##2 rec_time == $past(ts_reg, 2) - $past(pre_reg, 2);
  endproperty
  a_single_time: assert property (p_single_time) else $error("stamp not moved by offset"); // RULE2

  property p_fixed_start;
    @(posedge clk_sys) disable iff (!rst_b)
    (state_reg == cap_idle) & enable & (mode == mode_fixed) & trig_rise |=> state_reg == cap_run;
  endproperty
  a_fixed_start: assert property (p_fixed_start) else $error("fixed capture did not start"); // RULE3

  property p_scalar_time;
    @(posedge clk_sys) disable iff (!rst_b)
    cap_tick & ~block_mode |=> rec_valid & rec_has_time & rec_block_end;
  endproperty
  a_scalar_time: assert property (p_scalar_time) else $error("scalar point lacks stamp"); // RULE4

  property p_block_inner;
    @(posedge clk_sys) disable iff (!rst_b)
    cap_tick & block_mode & (blk_pos_reg != 32'h00000000) |=> rec_valid & ~rec_has_time;
  endproperty
  a_block_inner: assert property (p_block_inner) else $error("stamp inside a block"); // RULE5

  property p_subblock;
    @(posedge clk_sys) disable iff (!rst_b)
    cap_tick & block_mode & blk_wrap & (mode == mode_fixed) |=>
      rec_block_end & (blk_pos_reg == 32'h00000000) & (blk_cnt_reg == $past(blk_cnt_reg) + 1);
  endproperty
  a_subblock: assert property (p_subblock) else $error("sub-block not closed"); // RULE6

  property p_gated_stop;
    @(posedge clk_sys) disable iff (!rst_b)
    (state_reg == cap_run) & (mode == mode_gated) & ~trig & ~block_mode |->
      ~cap_tick ##1 state_reg == cap_idle;
  endproperty
  a_gated_stop: assert property (p_gated_stop) else $error("gated capture ran low"); // RULE7

  property p_gated_finish;
    @(posedge clk_sys) disable iff (!rst_b)
    (state_reg == cap_run) & enable & (mode == mode_gated) & block_mode
      & (blk_pos_reg != 32'h00000000) |=> state_reg == cap_run;
  endproperty
  a_gated_finish: assert property (p_gated_finish) else $error("gated block cut short"); // RULE8

  property p_cont_run;
    @(posedge clk_sys) disable iff (!rst_b)
    (state_reg == cap_run) & enable & (mode == mode_cont) |=> state_reg == cap_run;
  endproperty
  a_cont_run: assert property (p_cont_run) else $error("continuous capture stopped"); // RULE9

  property p_ts_count;
    @(posedge clk_sys) disable iff (!rst_b)
    sample_tick |=> ts_reg == $past(ts_reg) + 1;
  endproperty
  a_ts_count: assert property (p_ts_count) else $error("timestamp counter stalled"); // RULE13

  c_single: cover property (@(posedge clk_sys) disable iff (!rst_b) single_pend_reg ##1 rec_valid);
  c_subblock: cover property (@(posedge clk_sys) disable iff (!rst_b)
    cap_tick & blk_wrap & (mode == mode_fixed) & ~last_point);
  c_gated_late: cover property (@(posedge clk_sys) disable iff (!rst_b) cap_tick & ~trig);
endmodule // strobed_sample_capture
`default_nettype wire

// ---- bench/sample_source.sv ----
// sample_source: upstream stand-in, one sample tick every TICK_GAP cycles with rising data.
// assumes the capture unit's clk_sys domain; no back-pressure from the capture unit.
`default_nettype none
module sample_source #(
  parameter int          TICK_GAP  = 4,            // cycles between ticks
  parameter logic [31:0] DATA_BASE = 32'hA5000000  // value of the first sample
) (
  input  wire logic        clk_sys,      // system clock
  input  wire logic        rst_b,        // async reset, active low
  output logic             sample_tick,  // one pulse per sample
  output logic [31:0]      sample_data   // sample, held until the next tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int          gap_reg;
  logic [31:0] idx_reg;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gap_reg     <= 0;
      idx_reg     <= 32'h0;
      sample_tick <= 1'b0;
      sample_data <= 32'h0;
    end else begin
      gap_reg     <= (gap_reg == TICK_GAP - 1) ? 0 : gap_reg + 1;
      sample_tick <= (gap_reg == TICK_GAP - 1);
      if (gap_reg == TICK_GAP - 1) begin
        sample_data <= DATA_BASE + idx_reg;
        idx_reg     <= idx_reg + 1;
      end
    end
  end
endmodule  // sample_source
`default_nettype wire

// ---- bench/strobed_sample_capture_tb_top.sv ----
// strobed_sample_capture_tb_top: register and capture-mode tests of the capture unit.
// assumes capture_consts.svh on the include path and sample_source as the upstream block.
`include "capture_consts.svh"
`default_nettype none
module strobed_sample_capture_tb_top;
  import capture_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] BASE = 32'hA5000000;
  localparam logic [31:0] STORE_ID = "CAP1";
  logic        clk_sys, rst_b, trig, sample_tick, rec_valid, rec_has_time, rec_block_end;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic        rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [31:0] wdata, rdata, sample_data, rec_time, rec_value, c;
  logic [31:0] tick_cnt = 32'h0;
  logic [65:0] rec_q[$];
  int          n_errors, n_tests, cyc;

  sample_source #(.TICK_GAP(4), .DATA_BASE(BASE)) sample_source_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .sample_tick(sample_tick), .sample_data(sample_data));
  strobed_sample_capture strobed_sample_capture_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .sample_tick(sample_tick), .sample_data(sample_data),
    .trig(trig), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rec_valid(rec_valid), .rec_has_time(rec_has_time), .rec_time(rec_time),
    .rec_value(rec_value), .rec_block_end(rec_block_end));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // sample count, record collection and hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (sample_tick === 1'b1) tick_cnt <= tick_cnt + 1;
    if (rec_valid === 1'b1) rec_q.push_back({rec_has_time, rec_block_end, rec_time, rec_value});
    if (cyc == 3000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("store %s comparisons %0d mismatches %0d", STORE_ID, n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge clk_sys);
      ah = (awvalid & awready) === 1'b1;
      wh = (wvalid & wready) === 1'b1;
      bh = bvalid === 1'b1;
      r = bresp;
      @(posedge clk_sys);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge clk_sys);
      ah = (arvalid & arready) === 1'b1;
      rh = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk(r, `CAP_RESP_OKAY);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(d, e);
    chk(r, re);
  endtask

  // configure, enable, strobe two cycles after a sample tick, wait, disable
  task automatic run(input mode_type m, input logic [31:0] rate, per, dur, bs, nsub,
                     input int hold);
    rec_q.delete();
    wr(`CAP_ADDR_RATE, rate);
    wr(`CAP_ADDR_PERIOD, per);
    wr(`CAP_ADDR_DURATION, dur);
    wr(`CAP_ADDR_BLOCK_SIZE, bs);
    wr(`CAP_ADDR_SUBBLOCKS, nsub);
    wr(`CAP_ADDR_CTRL, {29'h0, m, 1'b1});
    do @(negedge clk_sys); while (sample_tick !== 1'b1);
    @(posedge clk_sys);
    @(posedge clk_sys);
    c = tick_cnt;
    trig <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    trig <= 1'b0;
    repeat (40) @(posedge clk_sys);
    wr(`CAP_ADDR_CTRL, 32'h0);
  endtask

  task automatic beat(input int i, input logic ht, input logic be, input logic [31:0] v);
    if (i >= rec_q.size()) chk(32'h0, 32'h1);
    else begin
      chk(rec_q[i][65], ht);
      chk(rec_q[i][64], be);
      chk(rec_q[i][31:0], v);
    end
  endtask

  function automatic logic [31:0] tm(input int i);
    return rec_q[i][63:32];
  endfunction

  initial begin
    logic [1:0] r;
    rst_b   = 1'b0;
    trig    = 1'b0;
    awaddr  = 8'h00;
    awvalid = 1'b0;
    wdata   = 32'h0;
    wstrb   = 4'hF;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = 8'h00;
    arvalid = 1'b0;
    rready  = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd_chk(`CAP_ADDR_CTRL, `CAP_RST_CTRL, `CAP_RESP_OKAY);
    rd_chk(`CAP_ADDR_RATE, `CAP_RST_RATE_HZ, `CAP_RESP_OKAY);
    rd_chk(`CAP_ADDR_PERIOD, `CAP_RST_PERIOD, `CAP_RESP_OKAY);
    rd_chk(`CAP_ADDR_DURATION, `CAP_RST_DURATION, `CAP_RESP_OKAY);
    rd_chk(`CAP_ADDR_PRE_OFFSET, `CAP_RST_PRE_OFFSET, `CAP_RESP_OKAY);
    rd_chk(`CAP_ADDR_BLOCK_SIZE, `CAP_RST_BLOCK_SIZE, `CAP_RESP_OKAY);
    rd_chk(`CAP_ADDR_SUBBLOCKS, `CAP_RST_SUBBLOCKS, `CAP_RESP_OKAY);
    rd_chk(`CAP_ADDR_STATUS, 32'h0, `CAP_RESP_OKAY);
    rd_chk(8'h40, 32'h0, `CAP_RESP_SLVERR);
    axi_wr(`CAP_ADDR_STATUS, 32'h1, r);
    chk(r, `CAP_RESP_SLVERR);
    axi_wr(8'h40, 32'h1, r);
    chk(r, `CAP_RESP_SLVERR);
    wr(`CAP_ADDR_PRE_OFFSET, 32'h1FF);
    rd_chk(`CAP_ADDR_PRE_OFFSET, 32'hFF, `CAP_RESP_OKAY);
    for (int k = 0; k < 4; k += 3) begin
      wr(`CAP_ADDR_PRE_OFFSET, k);
      run(mode_single, 32'd10, 32'd1, 32'd10, 32'd256, 32'd1, 3);
      chk(rec_q.size(), 1);
      beat(0, 1'b1, 1'b1, BASE + c - 1 - k);
      chk(tm(0), c - k);
    end
    for (int d = 3; d <= 10; d += 7) begin
      run(mode_fixed, 32'd10, 32'd1, d, 32'd2, 32'd2, 1);
      chk(rec_q.size(), (d == 3) ? 3 : 4);
      for (int i = 0; i < ((d == 3) ? 3 : 4); i++)
        beat(i, i % 2 == 0, i % 2 == 1 || (i == 2 && d == 3), BASE + c + i);
      chk(tm(2) - tm(0), 32'd2);
      chk(tm(0), c);
    end
    run(mode_fixed, 32'd5, 32'd2, 32'd3, 32'd2, 32'd2, 1);
    chk(rec_q.size(), 3);
    for (int i = 0; i < 3; i++) beat(i, 1'b1, 1'b1, BASE + c + 2 * i);
    chk(tm(2) - tm(0), 32'd4);
    run(mode_gated, 32'd10, 32'd1, 32'd10, 32'd4, 32'd1, 6);
    chk(rec_q.size(), 4);
    for (int i = 0; i < 4; i++) beat(i, i == 0, i == 3, BASE + c + i);
    chk(tm(0), c);
    run(mode_gated, 32'd5, 32'd1, 32'd10, 32'd4, 32'd1, 12);
    chk(rec_q.size(), 3);
    for (int i = 0; i < 3; i++) beat(i, 1'b1, 1'b1, BASE + c + i);
    run(mode_cont, 32'd5, 32'd1, 32'd10, 32'd4, 32'd1, 2);
    chk(rec_q.size() >= 10, 1);
    for (int i = 1; i < 10; i++) chk(rec_q[i][31:0] - rec_q[i - 1][31:0], 1);
    stop_test();
  end
endmodule  // strobed_sample_capture_tb_top
`default_nettype wire
